// File: rtl/nfci_pkg.sv
package nfci_pkg;
  localparam logic [10:0] NFCI_UNLOCK_ADDR1 = 11'h555;
  localparam logic [10:0] NFCI_UNLOCK_ADDR2 = 11'h2AA;
  localparam logic [7:0] NFCI_UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0] NFCI_UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] NFCI_CMD_RESET = 8'hF0;
  localparam logic [7:0] NFCI_CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] NFCI_CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] NFCI_CMD_BYPASS = 8'h20;
  localparam logic [7:0] NFCI_CMD_BYPASS_EXIT2 = 8'h00;
  localparam logic [7:0] NFCI_CMD_ERASE = 8'h80;
  localparam logic [7:0] NFCI_CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] NFCI_CMD_BLOCK_ERASE = 8'h30;
  localparam logic [7:0] NFCI_CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] NFCI_CMD_RESUME = 8'h30;
  localparam logic [16:0] NFCI_SIG_MAKER_ADDR = 17'h00000;
  localparam logic [16:0] NFCI_SIG_PART_ADDR = 17'h00001;
  localparam logic [16:0] NFCI_SIG_PROT_ADDR = 17'h00002;
  localparam int NFCI_CLK_MHZ = 25;
  localparam int NFCI_SETUP_NS = 80;
  localparam int NFCI_PULSE_NS = 120;
  localparam int NFCI_ABORT_US = 10;
  localparam int NFCI_SETUP_CYC = (NFCI_SETUP_NS * NFCI_CLK_MHZ + 999) / 1000;
  localparam int NFCI_PULSE_CYC = (NFCI_PULSE_NS * NFCI_CLK_MHZ + 999) / 1000;
  localparam int NFCI_ABORT_CYC = NFCI_ABORT_US * NFCI_CLK_MHZ;

  typedef enum logic [3:0] {
    NFCI_OP_READ = 4'h0,
    NFCI_OP_RESET = 4'h1,
    NFCI_OP_RESET3 = 4'h2,
    NFCI_OP_AUTOSEL = 4'h3,
    NFCI_OP_PROGRAM = 4'h4,
    NFCI_OP_BYPASS = 4'h5,
    NFCI_OP_BYP_PROG = 4'h6,
    NFCI_OP_BYP_EXIT = 4'h7,
    NFCI_OP_CHIP_ERASE = 4'h8,
    NFCI_OP_BLOCK_ERASE = 4'h9,
    NFCI_OP_SUSPEND = 4'hA,
    NFCI_OP_RESUME = 4'hB,
    NFCI_OP_SIG_READ = 4'hC
  } nfci_op_e;

  typedef struct packed {
    nfci_op_e op;
    logic [16:0] addr;
    logic [7:0] data;
  } nfci_req_s;

  typedef struct packed {
    logic chipEnN;
    logic outEnN;
    logic wrEnN;
    logic [16:0] addrIn;
    logic [7:0] dataOut;
    logic dataOe;
    logic idHighVoltage;
  } nfci_pins_s;
endpackage : nfci_pkg

// File: rtl/nfci_bus_cycle.sv
`timescale 1ns/1ps
// One bus cycle on the flash pins: setup, strobe low, release
module nfci_bus_cycle
  import nfci_pkg::*;
(
  input wire logic clk, // 25 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic start, // Pulse: begin a cycle
  input wire logic isWrite, // 1 write, 0 read
  input wire logic [16:0] addr, // Cycle address
  input wire logic [7:0] wdata, // Write data
  input wire logic idHv, // Identification voltage qualifier
  input wire logic [7:0] dataIn, // Data pins from flash
  output logic busy, // Cycle in progress
  output logic done, // Pulse: cycle finished
  output logic [7:0] rdata, // Captured read data
  output nfci_pins_s pins // Flash pin drive
);
  typedef enum logic [1:0] {
    NFCI_BC_IDLE = 2'b00,
    NFCI_BC_SETUP = 2'b01,
    NFCI_BC_STROBE = 2'b10,
    NFCI_BC_HOLD = 2'b11
  } nfci_bc_e;

  nfci_bc_e state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic wr_reg;
  logic strobeEnd;

  assign strobeEnd = (state_reg == NFCI_BC_STROBE) && (cnt_reg == 8'h00);
  assign busy = (state_reg != NFCI_BC_IDLE);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
    case (state_reg)
      NFCI_BC_IDLE:
        if (start)
        begin
          state_next = NFCI_BC_SETUP;
          cnt_next = 8'(NFCI_SETUP_CYC - 1);
        end
      NFCI_BC_SETUP:
        if (cnt_reg == 8'h00)
        begin
          state_next = NFCI_BC_STROBE;
          cnt_next = 8'(NFCI_PULSE_CYC - 1);
        end
      NFCI_BC_STROBE:
        if (cnt_reg == 8'h00)
        begin
          state_next = NFCI_BC_HOLD;
          cnt_next = 8'(NFCI_SETUP_CYC - 1);
        end
      default:
        if (cnt_reg == 8'h00)
          state_next = NFCI_BC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= NFCI_BC_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      pins <= '{chipEnN: 1'b1, outEnN: 1'b1, wrEnN: 1'b1, default: '0};
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done <= (state_reg == NFCI_BC_HOLD) && (cnt_reg == 8'h00);
      if (start && !busy)
      begin
        wr_reg <= isWrite;
        // Address stands before either strobe falls, data until after both rise
        pins.addrIn <= addr;
        pins.dataOut <= wdata;
        pins.dataOe <= isWrite;
        pins.idHighVoltage <= idHv && !isWrite;
      end
      // Read: CE and OE low, WE high; write: CE and WE low, OE high
      // CE stays low through hold so WE rises first and the data is latched under CE
      pins.chipEnN <= (state_next == NFCI_BC_IDLE);
      pins.wrEnN <= !(state_next == NFCI_BC_STROBE && wr_reg);
      pins.outEnN <= !(state_next == NFCI_BC_STROBE && !wr_reg);
      if (strobeEnd && !wr_reg)
        rdata <= dataIn;
      if (state_next == NFCI_BC_IDLE)
      begin
        pins.dataOe <= 1'b0;
        pins.idHighVoltage <= 1'b0;
      end
    end
  end
endmodule : nfci_bus_cycle

// File: rtl/nfci_host.sv
`timescale 1ns/1ps
// Function
// - Unlock AA@555, 55@2AA, code@555 (the reset code F0 and the block erase code 30 go to the request address)
// - Reset: F0 alone or after unlock
// - Auto select: unlock then 90@555
// - Program: unlock, A0@555, data@target
// - Bypass program: A0 anywhere, data@target
// - Bypass exit: 90 then 00 anywhere
// - Erase six writes: chip or block
// - Suspend B0, resume 30, any address
// - Address on falling, data rising strobe
module nfci_host
  import nfci_pkg::*;
(
  input wire logic clk, // 25 MHz clock
  input wire logic arst_n, // Async reset, active low
  input nfci_req_s req, // Requested operation
  input wire logic reqValid, // Request offered
  output logic reqReady, // High while idle: an offered request is taken this cycle
  output logic respValid, // Pulse: operation finished
  output logic [7:0] respData, // Data of last read
  output logic chipEnN, // Flash chip enable, low active
  output logic outEnN, // Flash output enable, low active
  output logic wrEnN, // Flash write enable, low active
  output logic [16:0] addr_in, // Flash address pins
  input wire logic [7:0] data_io_in, // Flash data pins, input side
  output logic [7:0] data_io_out, // Flash data pins, output side
  output logic data_io_oe, // High while host drives data pins
  output logic id_high_voltage // Identification voltage on address bit 9
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    NFCI_ST_IDLE = 2'b00,
    NFCI_ST_CYCLE = 2'b01,
    NFCI_ST_WAIT = 2'b10,
    NFCI_ST_DONE = 2'b11
  } nfci_st_e;

  nfci_st_e state_reg, state_next;
  nfci_req_s req_reg;
  logic [2:0] step_reg, step_next;
  logic [8:0] wait_reg, wait_next;
  logic [7:0] respData_reg;
  logic respValid_reg;
  logic cycStart, cycBusy, cycDone, cycWrite;
  logic [16:0] cycAddr;
  logic [7:0] cycData, cycRdata;
  logic lastStep, cycIdHv;
  logic [2:0] nSteps;
  nfci_pins_s pins;

  ////////////////////////////////////////////////////////////////////////////
  // Number of bus cycles per operation
  assign nSteps = (req_reg.op == NFCI_OP_READ || req_reg.op == NFCI_OP_RESET ||
                   req_reg.op == NFCI_OP_SUSPEND || req_reg.op == NFCI_OP_RESUME ||
                   req_reg.op == NFCI_OP_SIG_READ) ? 3'd1 :
                  (req_reg.op == NFCI_OP_BYP_PROG || req_reg.op == NFCI_OP_BYP_EXIT) ? 3'd2 :
                  (req_reg.op == NFCI_OP_PROGRAM) ? 3'd4 :
                  (req_reg.op == NFCI_OP_CHIP_ERASE || req_reg.op == NFCI_OP_BLOCK_ERASE) ? 3'd6 :
                  3'd3;
  assign lastStep = (step_reg == nSteps - 3'd1);

  // Unlock pair at steps 0,1 and 3,4 of the erase series
  logic unlockA, unlockB, isErase, isSingle, isBypass;
  assign isErase = (req_reg.op == NFCI_OP_CHIP_ERASE || req_reg.op == NFCI_OP_BLOCK_ERASE);
  assign isSingle = (nSteps == 3'd1);
  assign isBypass = (req_reg.op == NFCI_OP_BYP_PROG || req_reg.op == NFCI_OP_BYP_EXIT);
  assign unlockA = !isSingle && !isBypass && (step_reg == 3'd0 || (isErase && step_reg == 3'd3));
  assign unlockB = !isSingle && !isBypass && (step_reg == 3'd1 || (isErase && step_reg == 3'd4));

  // Command code of each series: its last write, except for program, where the data write follows it
  logic [7:0] codeData;
  assign codeData = (req_reg.op == NFCI_OP_RESET || req_reg.op == NFCI_OP_RESET3) ? NFCI_CMD_RESET :
                    (req_reg.op == NFCI_OP_AUTOSEL) ? NFCI_CMD_AUTOSEL :
                    (req_reg.op == NFCI_OP_PROGRAM) ? NFCI_CMD_PROGRAM :
                    (req_reg.op == NFCI_OP_BYPASS) ? NFCI_CMD_BYPASS :
                    (req_reg.op == NFCI_OP_SUSPEND) ? NFCI_CMD_SUSPEND :
                    (req_reg.op == NFCI_OP_RESUME) ? NFCI_CMD_RESUME :
                    (req_reg.op == NFCI_OP_CHIP_ERASE) ? NFCI_CMD_CHIP_ERASE :
                    NFCI_CMD_BLOCK_ERASE;

  // Upper address bits are don't care for command writes; the request's bits are kept
  logic [16:0] unlockAddr1, unlockAddr2;
  assign unlockAddr1 = {req_reg.addr[16:11], NFCI_UNLOCK_ADDR1};
  assign unlockAddr2 = {req_reg.addr[16:11], NFCI_UNLOCK_ADDR2};

  always_comb
  begin
    cycWrite = 1'b1;
    cycAddr = req_reg.addr;
    cycData = codeData;
    if (unlockA)
    begin
      cycAddr = unlockAddr1;
      cycData = NFCI_UNLOCK_DATA1;
    end
    else if (unlockB)
    begin
      cycAddr = unlockAddr2;
      cycData = NFCI_UNLOCK_DATA2;
    end
    else if (req_reg.op == NFCI_OP_READ || req_reg.op == NFCI_OP_SIG_READ)
      cycWrite = 1'b0;
    else if (req_reg.op == NFCI_OP_BYP_PROG)
      cycData = (step_reg == 3'd0) ? NFCI_CMD_PROGRAM : req_reg.data;
    else if (req_reg.op == NFCI_OP_BYP_EXIT)
      cycData = (step_reg == 3'd0) ? NFCI_CMD_AUTOSEL : NFCI_CMD_BYPASS_EXIT2;
    else if (req_reg.op == NFCI_OP_PROGRAM && step_reg == 3'd3)
      cycData = req_reg.data;
    else if (req_reg.op == NFCI_OP_CHIP_ERASE || (step_reg == 3'd2 && !isSingle &&
             req_reg.op != NFCI_OP_RESET3))
      cycAddr = unlockAddr1;
    if (isErase && step_reg == 3'd2)
      cycData = NFCI_CMD_ERASE;
  end
  // Identification voltage only during a signature read
  assign cycIdHv = (req_reg.op == NFCI_OP_SIG_READ);

  ////////////////////////////////////////////////////////////////////////////
  assign reqReady = (state_reg == NFCI_ST_IDLE);
  // Let the done pulse pass first, or the old step would be written a second time
  assign cycStart = (state_reg == NFCI_ST_CYCLE) && !cycBusy && !cycDone;

  always_comb
  begin
    state_next = state_reg;
    step_next = step_reg;
    wait_next = (wait_reg != 9'd0) ? wait_reg - 9'd1 : 9'd0;
    case (state_reg)
      NFCI_ST_IDLE:
        if (reqValid)
        begin
          state_next = NFCI_ST_CYCLE;
          step_next = 3'd0;
        end
      NFCI_ST_CYCLE:
        if (cycDone)
        begin
          if (!lastStep)
            step_next = step_reg + 3'd1;
          // Reset may need the abort period before reads are valid
          else if (req_reg.op == NFCI_OP_RESET || req_reg.op == NFCI_OP_RESET3)
          begin
            state_next = NFCI_ST_WAIT;
            wait_next = 9'(NFCI_ABORT_CYC - 1);
          end
          else
            state_next = NFCI_ST_DONE;
        end
      NFCI_ST_WAIT:
        if (wait_reg == 9'd0)
          state_next = NFCI_ST_DONE;
      default:
        state_next = NFCI_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= NFCI_ST_IDLE;
      step_reg <= 3'd0;
      wait_reg <= 9'd0;
      req_reg <= '0;
      respData_reg <= 8'h00;
      respValid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      step_reg <= step_next;
      wait_reg <= wait_next;
      if (reqValid && reqReady)
        req_reg <= req;
      if (cycDone && !cycWrite)
        respData_reg <= cycRdata;
      respValid_reg <= (state_next == NFCI_ST_DONE);
    end
  end

  assign respValid = respValid_reg;
  assign respData = respData_reg;

  ////////////////////////////////////////////////////////////////////////////
  nfci_bus_cycle u_cycle (
    .clk(clk),
    .arst_n(arst_n),
    .start(cycStart),
    .isWrite(cycWrite),
    .addr(cycAddr),
    .wdata(cycData),
    .idHv(cycIdHv),
    .dataIn(data_io_in),
    .busy(cycBusy),
    .done(cycDone),
    .rdata(cycRdata),
    .pins(pins)
  );

  assign chipEnN = pins.chipEnN;
  assign outEnN = pins.outEnN;
  assign wrEnN = pins.wrEnN;
  assign addr_in = pins.addrIn;
  assign data_io_out = pins.dataOut;
  assign data_io_oe = pins.dataOe;
  assign id_high_voltage = pins.idHighVoltage;
endmodule : nfci_host

// File: tb/nfci_flash_model.sv
`timescale 1ns/1ps
module nfci_flash_model
  import nfci_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'hC3, // Arbitrary value
  parameter logic [7:0] PROT_MASK = 8'h04 // Block 2 protected
)
(
  input wire logic chipEnN, // CE
  input wire logic outEnN, // OE
  input wire logic wrEnN, // WE
  input wire logic [16:0] addr_in, // Address
  input wire logic [7:0] data_io_out, // Host data
  input wire logic id_high_voltage, // Id voltage
  output logic [7:0] data_io_in // Flash data
);
  logic [7:0] mem [0:131071];
  logic [16:0] latAddr;
  logic [10:0] a;
  logic [7:0] d;
  logic [7:0] rd;
  logic drv;
  int step;
  int mode;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hFF;
    step = 0;
    mode = 0;
  end
  always @(negedge wrEnN) latAddr = addr_in;
  ////////////////////////////////////////////////////////////
  // Embedded operations finish at once, so no busy window or abort period
  always @(posedge wrEnN)
  begin
    a = latAddr[10:0];
    d = data_io_out;
    if (chipEnN) step = step;
    else if (step == 3)
    begin
      if (!PROT_MASK[latAddr[16:14]]) mem[latAddr] = mem[latAddr] & d;
      step = 0;
    end
    else if (mode == 2)
    begin
      if (step == 4 && d == 8'h00) mode = 0;
      step = (d == 8'hA0) ? 3 : (d == 8'h90) ? 4 : 0;
    end
    else if (d == 8'hF0)
    begin
      step = 0;
      mode = 0;
    end
    else if ((step == 0 || step == 5) && a == 11'h555 && d == 8'hAA) step++;
    else if ((step == 1 || step == 6) && a == 11'h2AA && d == 8'h55) step++;
    else if (step == 2 && a == 11'h555)
    begin
      mode = (d == 8'h90) ? 1 : (d == 8'h20) ? 2 : 0;
      step = (d == 8'hA0) ? 3 : (d == 8'h80) ? 5 : 0;
    end
    else if (step == 7)
    begin
      foreach (mem[i])
        if (!PROT_MASK[i[16:14]] && (d == 8'h10 || i[16:14] == latAddr[16:14])) mem[i] = 8'hFF;
      step = 0;
    end
    else
    begin
      // No erase runs here, so suspend and resume only end a sequence
      step = 0;
      mode = 0;
    end
  end
  ////////////////////////////////////////////////////////////
  assign drv = !chipEnN && !outEnN && wrEnN;
  always_comb
  begin
    if ((id_high_voltage || mode == 1) && addr_in[1:0] == 2'h0) rd = MAKER_CODE;
    else if ((id_high_voltage || mode == 1) && addr_in[1:0] == 2'h1) rd = PART_CODE;
    else if (mode == 1 && addr_in[1:0] == 2'h2) rd = {7'h00, PROT_MASK[addr_in[16:14]]};
    else rd = mem[addr_in];
  end
  // Released bus shows the inverse so a stale capture cannot pass
  assign data_io_in = drv ? rd : ~rd;
endmodule : nfci_flash_model

// File: tb/nfci_host_asserts.sv
`timescale 1ns/1ps
module nfci_host_asserts
  import nfci_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic reqValid, // Offer
  input wire logic reqReady, // Take
  input wire logic respValid, // Done
  input wire logic chipEnN, // CE
  input wire logic outEnN, // OE
  input wire logic wrEnN, // WE
  input wire logic [16:0] addr_in, // Address
  input wire logic [7:0] data_io_out, // Data
  input wire logic data_io_oe, // Drive
  input wire logic id_high_voltage // Id voltage
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_RW_EXCL: assert property (outEnN || wrEnN) else $error("both strobes low");
  AST_CE_QUAL: assert property (!outEnN || !wrEnN |-> !chipEnN) else $error("strobe without CE");
  AST_OE_WRITE: assert property (!wrEnN |-> data_io_oe && outEnN) else $error("write not driven");
  AST_NO_DRIVE_READ: assert property (!outEnN |-> !data_io_oe) else $error("drive on read");
  AST_IDHV: assert property (id_high_voltage |-> wrEnN) else $error("id voltage on write");
  AST_WE_PULSE: assert property ($fell(wrEnN) |-> (!wrEnN) [*3] ##1 wrEnN) else $error("WE width");
  AST_WE_HOLD: assert property (!wrEnN && $past(!wrEnN) |-> $stable(addr_in) && $stable(data_io_out))
    else $error("bus moved under WE");
  AST_CE_SETUP: assert property ($fell(wrEnN) |-> $past(!chipEnN)) else $error("WE before CE");
  AST_CE_HOLD: assert property ($rose(wrEnN) |-> !chipEnN) else $error("CE rose with WE");
  AST_TAKE: assert property (reqValid && reqReady |=> !reqReady) else $error("ready while busy");
  AST_RESP: assert property (respValid |-> chipEnN && wrEnN ##1 !respValid) else $error("bad done");
endmodule : nfci_host_asserts
bind nfci_host nfci_host_asserts nfci_host_asserts_i (.clk(clk), .arst_n(arst_n), .reqValid(reqValid),
  .reqReady(reqReady), .respValid(respValid), .chipEnN(chipEnN), .outEnN(outEnN), .wrEnN(wrEnN),
  .addr_in(addr_in), .data_io_out(data_io_out), .data_io_oe(data_io_oe), .id_high_voltage(id_high_voltage));

// File: tb/nfci_host_tb_top.sv
`timescale 1ns/1ps
module nfci_host_tb_top
  import nfci_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
  localparam logic [7:0] PART = 8'hC3; // Arbitrary value
  logic clk;
  logic arst_n;
  nfci_req_s req;
  logic reqValid, reqReady, respValid, chipEnN, outEnN, wrEnN, dataOe, idHv;
  logic [7:0] respData, dataIn, dataOut;
  logic [16:0] addrIn;
  int errors = 0;
  int nChecks = 0;
  int cycles = 0;
  nfci_host nfci_host_i (.clk(clk), .arst_n(arst_n), .req(req), .reqValid(reqValid), .reqReady(reqReady),
    .respValid(respValid), .respData(respData), .chipEnN(chipEnN), .outEnN(outEnN), .wrEnN(wrEnN),
    .addr_in(addrIn), .data_io_in(dataIn), .data_io_out(dataOut), .data_io_oe(dataOe), .id_high_voltage(idHv));
  nfci_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) nfci_flash_model_i (.chipEnN(chipEnN),
    .outEnN(outEnN), .wrEnN(wrEnN), .addr_in(addrIn), .data_io_out(dataOut), .id_high_voltage(idHv),
    .data_io_in(dataIn));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (errors == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Reset operations include the abort wait, hence the wide bound
  task automatic run_op(input nfci_op_e o, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{op: o, addr: a, data: d};
    reqValid <= 1'b1;
    @(posedge clk);
    while (reqReady !== 1'b1) @(posedge clk);
    reqValid <= 1'b0;
    while (respValid !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 2000)
    begin
      errors++;
      complete_run;
    end
  endtask : run_op
  task automatic rd(input nfci_op_e o, input logic [16:0] a, input logic [7:0] exp);
    run_op(o, a, 8'h00);
    check($sformatf("data at %h", a), respData, exp);
  endtask : rd
  ////////////////////////////////////////////////////////////
  task automatic sc_autosel;
    rd(NFCI_OP_SIG_READ, 17'h1FF00, MAKER);
    rd(NFCI_OP_SIG_READ, 17'h00001, PART);
    run_op(NFCI_OP_AUTOSEL, 17'h00000, 8'h00);
    rd(NFCI_OP_READ, 17'h1F7F0, MAKER);
    rd(NFCI_OP_READ, 17'h00001, PART);
    rd(NFCI_OP_READ, 17'h0A002, 8'h01);
    rd(NFCI_OP_READ, 17'h1C002, 8'h00);
    run_op(NFCI_OP_RESET3, 17'h00000, 8'h00);
    rd(NFCI_OP_READ, 17'h00001, 8'hFF);
    run_op(NFCI_OP_AUTOSEL, 17'h00000, 8'h00);
    run_op(NFCI_OP_RESET, 17'h12345, 8'h00);
    rd(NFCI_OP_READ, 17'h00000, 8'hFF);
  endtask : sc_autosel
  task automatic sc_program;
    run_op(NFCI_OP_PROGRAM, 17'h1C123, 8'h3C);
    rd(NFCI_OP_READ, 17'h1C123, 8'h3C);
    run_op(NFCI_OP_PROGRAM, 17'h1C123, 8'hC3);
    rd(NFCI_OP_READ, 17'h1C123, 8'h00);
    run_op(NFCI_OP_PROGRAM, 17'h09000, 8'h00);
    rd(NFCI_OP_READ, 17'h09000, 8'hFF);
  endtask : sc_program
  task automatic sc_bypass;
    run_op(NFCI_OP_BYPASS, 17'h00000, 8'h00);
    run_op(NFCI_OP_BYP_PROG, 17'h00200, 8'h5A);
    rd(NFCI_OP_READ, 17'h00200, 8'h5A);
    run_op(NFCI_OP_RESET, 17'h00000, 8'h00);
    run_op(NFCI_OP_BYP_PROG, 17'h00201, 8'hA5);
    rd(NFCI_OP_READ, 17'h00201, 8'hA5);
    run_op(NFCI_OP_BYP_EXIT, 17'h00000, 8'h00);
    run_op(NFCI_OP_BYP_PROG, 17'h00202, 8'h00);
    rd(NFCI_OP_READ, 17'h00202, 8'hFF);
  endtask : sc_bypass
  task automatic sc_erase;
    run_op(NFCI_OP_BLOCK_ERASE, 17'h00010, 8'h00);
    rd(NFCI_OP_READ, 17'h00200, 8'hFF);
    rd(NFCI_OP_READ, 17'h1C123, 8'h00);
    run_op(NFCI_OP_SUSPEND, 17'h01234, 8'h00);
    run_op(NFCI_OP_RESUME, 17'h04321, 8'h00);
    rd(NFCI_OP_READ, 17'h1C123, 8'h00);
    run_op(NFCI_OP_CHIP_ERASE, 17'h00000, 8'h00);
    rd(NFCI_OP_READ, 17'h1C123, 8'hFF);
  endtask : sc_erase
  ////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      complete_run;
    end
  end
  initial
  begin
    arst_n = 1'b0;
    reqValid = 1'b0;
    req = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    sc_autosel;
    sc_program;
    sc_bypass;
    sc_erase;
    complete_run;
  end
endmodule : nfci_host_tb_top
